// file: common/nad_cfg.svh
// constant definitions for the nibble alu and flags datapath
`ifndef NAD_CFG_SVH
`define NAD_CFG_SVH
`define NAD_OFS_OP        12'h000
`define NAD_OFS_OPERAND   12'h004
`define NAD_OFS_ACCUM     12'h008
`define NAD_OFS_FLAGS     12'h00c
`define NAD_OFS_RES       12'h010
`define NAD_OFS_MEM_ADDR  12'h014
`define NAD_OFS_MEM_DATA  12'h018
`define NAD_OFS_PORT_ADDR 12'h01c
`define NAD_OFS_PORT_DATA 12'h020
`define NAD_OFS_VARIANT   12'h024
`define NAD_BIT_CARRY     3
`define NAD_BIT_ZERO      2
`define NAD_BIT_BRANCH    1
`define NAD_BIT_SPARE     0
`define NAD_FLAGS_RESET   4'h2
`define NAD_MEM_MSB       7
`define NAD_NUM_PORTS     32
`endif

// file: common/nad_pkg.sv
// types shared by the nibble alu and flags datapath
package nad_pkg;
	typedef enum logic [4:0] {
		NAD_OP_IDLE   = 5'h00,
		NAD_OP_ADD    = 5'h01,
		NAD_OP_ADDC   = 5'h02,
		NAD_OP_SUB    = 5'h03,
		NAD_OP_SUBC   = 5'h04,
		NAD_OP_AND    = 5'h05,
		NAD_OP_OR     = 5'h06,
		NAD_OP_XOR    = 5'h07,
		NAD_OP_LD     = 5'h08,
		NAD_OP_ROL    = 5'h09,
		NAD_OP_ROR    = 5'h0a,
		NAD_OP_BR     = 5'h0b,
		NAD_OP_GSET   = 5'h0c,
		NAD_OP_GCLR   = 5'h0d,
		NAD_OP_GTST   = 5'h0e,
		NAD_OP_INTACC = 5'h0f,
		NAD_OP_INTERRUPT_RETURN_OP   = 5'h10,
		NAD_OP_MRD    = 5'h11,
		NAD_OP_MWR    = 5'h12,
		NAD_OP_PIN    = 5'h13,
		NAD_OP_POUT   = 5'h14
	} nad_op_t;

	typedef struct packed {
		logic       carry_bit;
		logic       zero_bit;
		logic       branch_condition_bit;
		logic       user_spare_bit;
	} nad_flags_t;

	typedef struct packed {
		logic [3:0] res;
		logic       c;
		logic       z;
	} nad_alu_t;

	typedef struct packed {
		logic [3:0]   accum_reg;
		nad_flags_t   flags;
		nad_flags_t   saved_flags;
		logic [3:0]   operand;
		logic [7:0]   mem_addr_buffer;
		logic [4:0]   port_addr;
		logic         branch_taken;
		logic         small_variant;
		logic [31:0]  prdata;
	} nad_state_t;
endpackage

// file: design/nad_core.sv
// nibble alu, accumulator, condition flags, data memory and port space
`timescale 1ns/100ps
`include "nad_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Operation
// - large variant: 256 nibble words, 00-ff
// - small variant ignores address msb
// - special c0-ff words land at 40-7f
// - alu gives 4-bit result, carry, zero
// - accumulator is operand source and destination
// - add carry is carry out of msb
// - subtract adds complement, carry means no borrow
// - zero detect on alu output or load
// - flags: carry3 zero2 status1 general0
// - interrupt pushes flags, return restores them
// - carry flag feeds and captures with-carry ops
// - rotate loads carry with shifted-out bit
// - zero flag updates only when instruction says
// - status flag defaults one, cleared by condition
// - branch taken only when status flag one
// - status forced one at reset and interrupt
// - general flag set, clear, test by software
// - 5-bit port address, locations 0-31
// - port space separate from memory spaces
// - output ports latch last written value
// - input ports pass pins unlatched
// - peripheral status separate from status flag
module nad_core #(
	parameter int MEM_WORDS = 256,
	parameter int NUM_PORTS = `NAD_NUM_PORTS
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NUM_PORTS*4-1:0] port_in,
	output logic      [NUM_PORTS*4-1:0] port_out,
	input  wire logic [3:0]            periph_status
);

	//////////////////////////////////////////////////////////////////////////
	nad_pkg::nad_state_t st_r;
	nad_pkg::nad_state_t st_nxt;
	logic [3:0]          mem_r   [MEM_WORDS];
	logic [3:0]          pout_r  [NUM_PORTS];

	logic                wr_acc;
	logic                rd_acc;
	nad_pkg::nad_op_t    op;
	nad_pkg::nad_alu_t   alu;
	logic [7:0]          phys_addr;
	logic [3:0]          pin_val;

	assign wr_acc  = psel & penable & pwrite;
	assign rd_acc  = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign op      = nad_pkg::nad_op_t'(pwdata[4:0]);

	// zero detect shared by alu results and plain loads
	function automatic logic is_zero(input logic [3:0] v);
		return v == 4'h0;
	endfunction

	// the msb is dropped on the small part, so c0-ff folds onto 40-7f
	function automatic logic [7:0] map_addr(input logic [7:0] a,
		input logic is_small);
		logic [7:0] m;
		m = a;
		if (is_small) begin
			m[`NAD_MEM_MSB] = 1'b0;
		end
		return m;
	endfunction

	function automatic logic unmapped(input logic [11:0] a);
		return (a > `NAD_OFS_VARIANT) || (a[1:0] != 2'b00);
	endfunction

	assign phys_addr = map_addr(st_r.mem_addr_buffer, st_r.small_variant);
	// port reads go straight from the pins, no capture stage
	assign pin_val   = port_in[st_r.port_addr*4 +: 4];
	assign pslverr   = psel & penable & unmapped(paddr);

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		alu = '0;
		case (op)
			nad_pkg::NAD_OP_ADD: begin
				{alu.c, alu.res} = {1'b0, st_r.accum_reg} +
					{1'b0, st_r.operand};
			end
			nad_pkg::NAD_OP_ADDC: begin
				{alu.c, alu.res} = {1'b0, st_r.accum_reg} +
					{1'b0, st_r.operand} +
					{4'h0, st_r.flags.carry_bit};
			end
			nad_pkg::NAD_OP_SUB: begin
				{alu.c, alu.res} = {1'b0, st_r.accum_reg} +
					{1'b0, ~st_r.operand} + 5'h01;
			end
			nad_pkg::NAD_OP_SUBC: begin
				{alu.c, alu.res} = {1'b0, st_r.accum_reg} +
					{1'b0, ~st_r.operand} +
					{4'h0, st_r.flags.carry_bit};
			end
			nad_pkg::NAD_OP_AND: alu.res = st_r.accum_reg & st_r.operand;
			nad_pkg::NAD_OP_OR:  alu.res = st_r.accum_reg | st_r.operand;
			nad_pkg::NAD_OP_XOR: alu.res = st_r.accum_reg ^ st_r.operand;
			nad_pkg::NAD_OP_LD:  alu.res = st_r.operand;
			nad_pkg::NAD_OP_ROL: begin
				{alu.c, alu.res} = {st_r.accum_reg,
					st_r.flags.carry_bit};
			end
			nad_pkg::NAD_OP_ROR: begin
				{alu.res, alu.c} = {st_r.flags.carry_bit,
					st_r.accum_reg};
			end
			nad_pkg::NAD_OP_MRD: alu.res = mem_r[phys_addr];
			nad_pkg::NAD_OP_PIN: alu.res = pin_val;
			default: alu.res = st_r.accum_reg;
		endcase
		alu.z = is_zero(alu.res);
	end

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.prdata = '0;
		if (wr_acc && !unmapped(paddr)) begin
			if (paddr == `NAD_OFS_OP) begin
				// status flag returns to one for each op that does not set it below
				st_nxt.flags.branch_condition_bit = 1'b1;
				st_nxt.branch_taken = 1'b0;
				case (op)
					nad_pkg::NAD_OP_ADD, nad_pkg::NAD_OP_ADDC: begin
						st_nxt.accum_reg = alu.res;
						st_nxt.flags.carry_bit = alu.c;
						st_nxt.flags.zero_bit = alu.z;
						st_nxt.flags.branch_condition_bit = ~alu.c;
					end
					nad_pkg::NAD_OP_SUB, nad_pkg::NAD_OP_SUBC: begin
						st_nxt.accum_reg = alu.res;
						st_nxt.flags.carry_bit = alu.c;
						st_nxt.flags.zero_bit = alu.z;
						st_nxt.flags.branch_condition_bit = alu.c;
					end
					nad_pkg::NAD_OP_AND, nad_pkg::NAD_OP_OR,
					nad_pkg::NAD_OP_XOR, nad_pkg::NAD_OP_LD,
					nad_pkg::NAD_OP_MRD, nad_pkg::NAD_OP_PIN: begin
						st_nxt.accum_reg = alu.res;
						st_nxt.flags.zero_bit = alu.z;
						st_nxt.flags.branch_condition_bit = ~alu.z;
					end
					nad_pkg::NAD_OP_ROL, nad_pkg::NAD_OP_ROR: begin
						st_nxt.accum_reg = alu.res;
						st_nxt.flags.carry_bit = alu.c;
					end
					nad_pkg::NAD_OP_BR: begin
						st_nxt.branch_taken =
							st_r.flags.branch_condition_bit;
					end
					nad_pkg::NAD_OP_GSET: begin
						st_nxt.flags.user_spare_bit = 1'b1;
					end
					nad_pkg::NAD_OP_GCLR: begin
						st_nxt.flags.user_spare_bit = 1'b0;
					end
					nad_pkg::NAD_OP_GTST: begin
						st_nxt.flags.branch_condition_bit =
							st_r.flags.user_spare_bit;
					end
					nad_pkg::NAD_OP_INTACC: begin
						// push happens first, status forced after it
						st_nxt.saved_flags = st_r.flags;
						st_nxt.flags.branch_condition_bit = 1'b1;
					end
					nad_pkg::NAD_OP_INTERRUPT_RETURN_OP: begin
						st_nxt.flags = st_r.saved_flags;
					end
					default: ;
				endcase
			end else if (paddr == `NAD_OFS_OPERAND) begin
				st_nxt.operand = pwdata[3:0];
			end else if (paddr == `NAD_OFS_ACCUM) begin
				st_nxt.accum_reg = pwdata[3:0];
			end else if (paddr == `NAD_OFS_FLAGS) begin
				st_nxt.flags = nad_pkg::nad_flags_t'(pwdata[3:0]);
			end else if (paddr == `NAD_OFS_MEM_ADDR) begin
				st_nxt.mem_addr_buffer = pwdata[7:0];
			end else if (paddr == `NAD_OFS_PORT_ADDR) begin
				st_nxt.port_addr = pwdata[4:0];
			end else if (paddr == `NAD_OFS_VARIANT) begin
				st_nxt.small_variant = pwdata[0];
			end
		end
		if (psel && !penable && !pwrite) begin
			if (paddr == `NAD_OFS_ACCUM) begin
				st_nxt.prdata = {28'h0, st_r.accum_reg};
			end else if (paddr == `NAD_OFS_OPERAND) begin
				st_nxt.prdata = {28'h0, st_r.operand};
			end else if (paddr == `NAD_OFS_FLAGS) begin
				// peripheral status sits beside, never inside, the flags
				st_nxt.prdata = {24'h0, periph_status, st_r.flags};
			end else if (paddr == `NAD_OFS_RES) begin
				st_nxt.prdata = {25'h0, st_r.branch_taken, alu.c, alu.z,
					alu.res};
			end else if (paddr == `NAD_OFS_MEM_ADDR) begin
				st_nxt.prdata = {16'h0, phys_addr,
					st_r.mem_addr_buffer};
			end else if (paddr == `NAD_OFS_MEM_DATA) begin
				st_nxt.prdata = {28'h0, mem_r[phys_addr]};
			end else if (paddr == `NAD_OFS_PORT_ADDR) begin
				st_nxt.prdata = {27'h0, st_r.port_addr};
			end else if (paddr == `NAD_OFS_PORT_DATA) begin
				st_nxt.prdata = {24'h0, pout_r[st_r.port_addr], pin_val};
			end else if (paddr == `NAD_OFS_VARIANT) begin
				st_nxt.prdata = {31'h0, st_r.small_variant};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.flags <= nad_pkg::nad_flags_t'(`NAD_FLAGS_RESET);
		end else begin
			st_r <= st_nxt;
		end
	end

	// data memory and port latches: separate address spaces
	always_ff @(posedge pclk) begin
		if (wr_acc && paddr == `NAD_OFS_MEM_DATA) begin
			mem_r[phys_addr] <= pwdata[3:0];
		end
		if (wr_acc && paddr == `NAD_OFS_OP &&
			op == nad_pkg::NAD_OP_MWR) begin
			mem_r[phys_addr] <= st_r.accum_reg;
		end
	end

	// ports hold until overwritten; reset clears them to a known level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				pout_r[i] <= 4'h0;
			end
		end else if (wr_acc && paddr == `NAD_OFS_PORT_DATA) begin
			pout_r[st_r.port_addr] <= pwdata[3:0];
		end else if (wr_acc && paddr == `NAD_OFS_OP &&
			op == nad_pkg::NAD_OP_POUT) begin
			pout_r[st_r.port_addr] <= st_r.accum_reg;
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			port_out[i*4 +: 4] = pout_r[i];
		end
	end

	assign prdata       = st_r.prdata;

endmodule

// file: tb/nad_core_props.sv
// concurrent checks on the apb and port pins of the datapath core
`timescale 1ns/100ps
`include "nad_cfg.svh"
module nad_core_props #(
	parameter int MEM_WORDS = 256,
	parameter int NUM_PORTS = 32
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [NUM_PORTS*4-1:0] port_in,
	input wire logic [NUM_PORTS*4-1:0] port_out,
	input wire logic [3:0]             periph_status
);
	logic [4:0] pa_r;
	logic       acc;
	logic       pd_wr;
	logic       po_wr;
	logic [NUM_PORTS*4-1:0] one_nib;
	logic [NUM_PORTS*4-1:0] keep_mask;
	logic [3:0] pin_sel;
	logic [3:0] out_sel;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign acc = psel && penable;
	assign pd_wr = acc && pwrite && paddr == `NAD_OFS_PORT_DATA;
	// the accumulator-to-port op is the other legal way to move a port
	assign po_wr = acc && pwrite && paddr == `NAD_OFS_OP &&
		pwdata[4:0] == nad_pkg::NAD_OP_POUT;
	assign one_nib = {{(NUM_PORTS*4-4){1'b0}}, 4'hf};
	assign keep_mask = ~(one_nib << (pa_r*4));
	assign pin_sel = port_in[pa_r*4 +: 4];
	assign out_sel = port_out[pa_r*4 +: 4];
	// shadow of the selected port, needed to know which nibble moves
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pa_r <= 5'h00;
		else if (acc && pwrite && paddr == `NAD_OFS_PORT_ADDR)
			pa_r <= pwdata[4:0];
	end
	sequence s_rd(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a ##1 psel && penable;
	endsequence
	a_status_read: assert property (s_rd(`NAD_OFS_FLAGS) |->
		prdata[7:4] == $past(periph_status)) else $error("status bad");
	a_flag_width: assert property (s_rd(`NAD_OFS_FLAGS) |->
		prdata[31:8] == 24'h000000) else $error("flag width bad");
	a_pin_read: assert property (s_rd(`NAD_OFS_PORT_DATA) |->
		prdata[3:0] == $past(pin_sel)) else $error("pin read bad");
	a_port_latch: assert property (pd_wr |=>
		out_sel == $past(pwdata[3:0])) else $error("port latch bad");
	a_port_hold: assert property (!(pd_wr || po_wr) |=>
		$stable(port_out)) else $error("port moved");
	a_port_keep: assert property ((pd_wr || po_wr) |=>
		((port_out ^ $past(port_out)) & keep_mask) == '0)
		else $error("other port moved");
	a_port_reset: assert property ($rose(presetn) |->
		port_out == '0) else $error("port reset bad");
	a_map_ok: assert property (acc && paddr <= 12'h024 &&
		paddr[1:0] == 2'h0 |-> pready && !pslverr) else $error("map bad");
	a_unmap_err: assert property (acc && paddr > 12'h024 &&
		!pwrite |-> pslverr && prdata == 32'h0) else $error("unmap bad");
endmodule

// file: tb/nad_pins.sv
// far-side pin source that drives the input port nibbles
`timescale 1ns/100ps
module nad_pins (
	input  wire logic         pclk,
	input  wire logic [127:0] val,
	output logic      [127:0] port_in
);
	// the source changes only when the bench asks, so a read sees
	// steady pins for its whole transfer
	always_ff @(posedge pclk) begin
		port_in <= val;
	end
endmodule

// file: tb/tb.sv
// self-checking bench for the nibble alu and flags datapath
`timescale 1ns/100ps
`include "nad_cfg.svh"
module tb;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, q;
	logic [127:0] port_in, port_out, pin_val, po;
	logic [3:0]   periph_status;
	int           err_total, num_checks, a, b, f, sv, s, c, i, n, v, m;
	nad_core i_nad_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_in(port_in), .port_out(port_out),
		.periph_status(periph_status));
	nad_pins i_nad_pins (.pclk(pclk), .val(pin_val), .port_in(port_in));
	initial begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(string nm, logic [127:0] seen, logic [127:0] x);
		num_checks++;
		if (seen !== x) begin
			err_total++;
			$display("BAD %s exp %h seen %h", nm, x, seen);
		end
	endtask
	task automatic bus(logic w, logic [11:0] ad, logic [31:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// no wait-state count is assumed; the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata; e = pslverr;
		psel <= 0; penable <= 0;
	endtask
	// run one op on the model, then compare accumulator and flags
	task automatic run(int o);
		bus(1, `NAD_OFS_OP, o);
		c = f[3]; s = a; m = 'hf;
		if (o == 11) begin
			bus(0, `NAD_OFS_RES, 0);
			chk("branch", q[6], f[1]);
		end
		case (o)
		1, 2: s = a + b + (o == 2 ? c : 0);
		3, 4: s = a + (~b & 15) + (o == 4 ? c : 1);
		5: s = a & b;
		6: s = a | b;
		7: s = a ^ b;
		8: s = b;
		9: begin s = (a << 1) | c; f[3] = a[3]; end
		10: begin s = (c << 3) | (a >> 1); f[3] = a[0]; end
		12: f[0] = 1;
		13: f[0] = 0;
		15: sv = f;
		default: ;
		endcase
		if (o < 9) f[2] = (s & 15) == 0;
		if (o < 5) f[3] = s[4];
		f[1] = o < 3 ? !s[4] : o < 5 ? s[4] : o < 9 ? !f[2] : 1;
		if (o == 14) f[1] = f[0];
		if (o == 16) f = sv;
		a = s & 15;
		bus(0, `NAD_OFS_ACCUM, 0);
		chk("accum", q, a);
		bus(0, `NAD_OFS_FLAGS, 0);
		chk("flags", q[3:0] & m, f & m);
		chk("periph", q[7:4], periph_status);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		close_out();
	end
	initial begin
		psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		presetn = 0; pin_val = 0; po = 0;
		void'($urandom(53647));
		periph_status = $urandom % 16;
		repeat (6) @(posedge pclk);
		presetn <= 1;
		bus(0, `NAD_OFS_FLAGS, 0);
		chk("rst flags", q[7:0], {periph_status, 4'h2});
		a = 0; f = 2; b = 9;
		bus(1, `NAD_OFS_OPERAND, b);
		run(15);
		$display("test reset done");
		for (i = 0; i < 60; i++) begin
			a = $urandom % 16; b = $urandom % 16; f = $urandom % 16;
			periph_status <= 4'($urandom % 16);
			bus(1, `NAD_OFS_OPERAND, b);
			bus(1, `NAD_OFS_ACCUM, a);
			bus(1, `NAD_OFS_FLAGS, f);
			run(1 + $urandom % 16);
		end
		$display("test alu done");
		for (i = 0; i < 2; i++) begin
			bus(1, `NAD_OFS_VARIANT, i);
			bus(1, `NAD_OFS_MEM_ADDR, 'h45);
			bus(1, `NAD_OFS_MEM_DATA, 'h3);
			bus(1, `NAD_OFS_MEM_ADDR, 'hc5);
			bus(1, `NAD_OFS_MEM_DATA, 'ha);
			bus(0, `NAD_OFS_MEM_ADDR, 0);
			chk("phys", q[15:8], i ? 'h45 : 'hc5);
			bus(1, `NAD_OFS_MEM_ADDR, 'h45);
			bus(0, `NAD_OFS_MEM_DATA, 0);
			chk("mem", q[3:0], i ? 'ha : 'h3);
		end
		// small variant, buffer at 45: the op path folds c5 as well
		bus(1, `NAD_OFS_ACCUM, 'h6);
		bus(1, `NAD_OFS_OP, 'h12);
		bus(1, `NAD_OFS_MEM_ADDR, 'hc5);
		bus(0, `NAD_OFS_MEM_DATA, 0);
		chk("mem wr op", q[3:0], 'h6);
		bus(1, `NAD_OFS_ACCUM, 0);
		bus(1, `NAD_OFS_OP, 'h11);
		bus(0, `NAD_OFS_ACCUM, 0);
		chk("mem rd op", q[3:0], 'h6);
		$display("test memory done");
		for (i = 0; i < 4; i++) begin
			n = i == 0 ? 31 : $urandom % 32; v = $urandom % 16;
			pin_val <= {$urandom, $urandom, $urandom, $urandom};
			po[n*4 +: 4] = v[3:0];
			bus(1, `NAD_OFS_PORT_ADDR, n);
			bus(1, `NAD_OFS_PORT_DATA, v);
			// the latch moves on the access edge; look one edge later
			@(posedge pclk);
			chk("port out", port_out, po);
			bus(0, `NAD_OFS_PORT_DATA, 0);
			chk("port rd", q[7:0], {v[3:0], pin_val[n*4 +: 4]});
		end
		bus(1, `NAD_OFS_ACCUM, v ^ 'h5);
		bus(1, `NAD_OFS_OP, 'h14);
		po[n*4 +: 4] = 4'(v ^ 'h5);
		@(posedge pclk);
		chk("pout op", port_out, po);
		bus(1, `NAD_OFS_OP, 'h13);
		bus(0, `NAD_OFS_ACCUM, 0);
		chk("pin op", q[3:0], pin_val[n*4 +: 4]);
		bus(0, `NAD_OFS_FLAGS, 0);
		chk("pin zero", q[2], pin_val[n*4 +: 4] == 4'h0);
		$display("test ports done");
		bus(1, 12'h100, 'hf);
		chk("unmap err", e, 1);
		bus(0, 12'h100, 0);
		chk("unmap rd", {e, q}, {1'b1, 32'h0});
		$display("test unmapped done");
		close_out();
	end
endmodule
bind nad_core nad_core_props #(.MEM_WORDS(MEM_WORDS), .NUM_PORTS(NUM_PORTS))
	i_nad_core_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_in(port_in), .port_out(port_out),
	.periph_status(periph_status));
